// File: src/ipc_ctrl.sv
// interrupt priority controller: seven adc pair sources, traps, apb regs
// assumes: single clock pclk, async active-low presetn, apb master outside
`timescale 1ns/1ps
`include "ipc_map.svh"
module ipc_ctrl #(
  parameter int                 NSRC       = 7,
  parameter logic [15:0]        TMASK_COUNT = `IPC_TMASK_CYCLES
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [NSRC-1:0]  src_event,
  input  wire logic             trap_event,
  input  wire logic             irq_ack,
  input  wire logic             handler_return,
  input  wire logic             timed_mask_start,
  output logic                  irq_req,
  output logic      [6:0]       irq_vector,
  output ipc_pkg::ipc_cpu_level_t irq_level,
  output ipc_pkg::ipc_cpu_level_t cpu_level,
  output logic                  irq_out
);
  import ipc_pkg::*;

  // ==========================================================
  // apb decode
  // ==========================================================
  wire acc     = psel && penable;
  wire wr      = acc && pwrite;
  wire rd      = acc && !pwrite;
  wire setup   = psel && !penable;
  wire hit_p01 = paddr == `IPC_OFS_PAIR01;
  wire hit_p25 = paddr == `IPC_OFS_PAIR2TO5;
  wire hit_p6  = paddr == `IPC_OFS_PAIR6;
  wire hit_pvs = paddr == `IPC_OFS_PEND_STATUS;
  wire hit_ctl = paddr == `IPC_OFS_CONTROL;
  wire hit_flg = paddr == `IPC_OFS_FLAGS;
  wire hit_ena = paddr == `IPC_OFS_ENABLES;
  wire hit_lvl = paddr == `IPC_OFS_CPU_LEVEL;
  wire hit_evs = paddr == `IPC_OFS_EVT_STATUS;
  wire hit_evm = paddr == `IPC_OFS_EVT_MASK;
  wire mapped  = hit_p01 | hit_p25 | hit_p6 | hit_pvs | hit_ctl |
                 hit_flg | hit_ena | hit_lvl | hit_evs | hit_evm;

  // ==========================================================
  // state
  // ==========================================================
  ipc_level_t      lvl_q [NSRC];
  logic [NSRC-1:0] flag_q;
  logic [NSRC-1:0] ena_q;
  logic            nest_off_q;
  logic            trap_flag_q;
  ipc_cpu_level_t  cpu_q;
  ipc_cpu_level_t  saved_q;
  logic            in_handler_q;
  logic [15:0]     tmask_q;
  logic [1:0]      evs_q;
  logic [1:0]      evm_q;
  ipc_state_t      state_q;
  logic            irq_req_q;

  // ==========================================================
  // source priority fields
  // ==========================================================
  // field position of source i within its register
  function automatic int fpos(input int i);
    case (i)
      0: fpos = 8;
      1: fpos = 12;
      2: fpos = 0;
      3: fpos = 4;
      4: fpos = 8;
      5: fpos = 12;
      default: fpos = 0;
    endcase
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_src
      localparam int P = fpos(gi);
      wire sel = (gi < 2) ? hit_p01 : (gi < 6) ? hit_p25 : hit_p6;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lvl_q[gi] <= `IPC_LEVEL_RESET;
        end else if (wr && sel) begin
          lvl_q[gi] <= pwdata[P+:3];
        end
      end
    end
  endgenerate

  // ==========================================================
  // arbitration
  // ==========================================================
  // masking threshold: cpu level, raised to 6 during timed mask
  wire tmask_on = tmask_q != 16'h0000;
  wire [3:0] thr = (tmask_on && cpu_q < 4'h6) ? 4'h6 : cpu_q;
  wire [3:0] thr_n = (nest_off_q && in_handler_q) ? 4'h7 : thr;

  logic [2:0] best_lvl;
  logic [6:0] best_idx;
  always_comb begin
    best_lvl = 3'h0;
    best_idx = 7'h00;
    // lower index scanned last and taken if equal or higher: ties keep lower
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (flag_q[i] && ena_q[i] && lvl_q[i] != 3'h0 &&
          lvl_q[i] >= best_lvl && {1'b0, lvl_q[i]} > thr_n) begin
        best_lvl = lvl_q[i];
        best_idx = 7'(i + 1);
      end
    end
  end
  wire user_pend = best_lvl != 3'h0;
  wire trap_pend = trap_flag_q && cpu_q != 4'hF;
  wire [3:0] win_lvl = trap_pend ? 4'hF : {1'b0, best_lvl};
  wire [6:0] win_vec = trap_pend ? 7'h00 : best_idx;
  wire any_pend = trap_pend || user_pend;
  // an ack only counts while an offer stands, so a late ack after the
  // source was cleared cannot stack a stale level
  wire take = any_pend && irq_ack && irq_req_q;

  // ==========================================================
  // flags, enables, control
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
      ena_q  <= '0;
    end else begin
      // event set wins over software clear; flag stays until cleared
      flag_q <= ((wr && hit_flg) ? pwdata[NSRC-1:0] : flag_q) | src_event;
      if (wr && hit_ena) ena_q <= pwdata[NSRC-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nest_off_q  <= 1'b0;
      trap_flag_q <= 1'b0;
    end else begin
      if (wr && hit_ctl) nest_off_q <= pwdata[`IPC_NEST_OFF_BIT];
      // trap flag sticky; only a write of zero clears it
      trap_flag_q <= ((wr && hit_ctl) ? pwdata[0] : trap_flag_q) |
                     trap_event;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmask_q <= 16'h0000;
    end else if (timed_mask_start) begin
      tmask_q <= TMASK_COUNT;
    end else if (tmask_on) begin
      tmask_q <= tmask_q - 16'h0001;
    end
  end

  // ==========================================================
  // cpu level, entry and return
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_q        <= 4'h0;
      saved_q      <= 4'h0;
      in_handler_q <= 1'b0;
      state_q      <= IPC_IDLE;
    end else if (take) begin
      saved_q      <= cpu_q;
      cpu_q        <= win_lvl;
      in_handler_q <= 1'b1;
      state_q      <= IPC_ACTIVE;
    end else if (handler_return) begin
      cpu_q        <= saved_q;
      in_handler_q <= 1'b0;
      state_q      <= IPC_IDLE;
    end else if (wr && hit_lvl) begin
      cpu_q <= pwdata[3:0];
    end
  end

  // ==========================================================
  // request outputs and event interrupt
  // ==========================================================
  logic [6:0] vec_q;
  logic [3:0] new_lvl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_q <= 1'b0;
      vec_q     <= 7'h00;
      new_lvl_q <= 4'h0;
    end else begin
      irq_req_q <= any_pend && !take;
      vec_q     <= win_vec;
      new_lvl_q <= win_lvl;
    end
  end
  assign irq_req    = irq_req_q;
  assign irq_vector = vec_q;
  assign irq_level  = new_lvl_q;
  assign cpu_level  = cpu_q;

  // event 0: entry taken, event 1: trap raised
  wire [1:0] ev_set = {trap_event, take};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evs_q   <= 2'b00;
      evm_q   <= 2'b00;
      irq_out <= 1'b0;
    end else begin
      evs_q   <= ((rd && hit_evs) ? 2'b00 : evs_q) | ev_set;
      if (wr && hit_evm) evm_q <= pwdata[1:0];
      irq_out <= |(((rd && hit_evs) ? 2'b00 : evs_q) & evm_q) |
                 |(ev_set & evm_q);
    end
  end

  // ==========================================================
  // read mux
  // ==========================================================
  wire [31:0] r01 = {17'h0, lvl_q[1], 1'b0, lvl_q[0], 8'h00};
  wire [31:0] r25 = {17'h0, lvl_q[5], 1'b0, lvl_q[4], 1'b0,
                     lvl_q[3], 1'b0, lvl_q[2]};
  wire [31:0] r6  = {29'h0, lvl_q[6]};
  wire [31:0] rpv = {20'h0, new_lvl_q, 1'b0, vec_q};
  wire [31:0] rd_mux =
      hit_p01 ? r01 : hit_p25 ? r25 : hit_p6 ? r6 : hit_pvs ? rpv :
      hit_ctl ? {16'h0, nest_off_q, 14'h0, trap_flag_q} :
      hit_flg ? {25'h0, flag_q} : hit_ena ? {25'h0, ena_q} :
      hit_lvl ? {28'h0, cpu_q} : hit_evs ? {30'h0, evs_q} :
      hit_evm ? {30'h0, evm_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // steps of one interrupt: offer, entry, return
  sequence s_offer;  any_pend && !take; endsequence
  sequence s_enter;  take; endsequence
  sequence s_return; handler_return && !take; endsequence

  reset_level_a: assert property (
    $rose(presetn) |-> lvl_q[0] == 3'h4 && lvl_q[6] == 3'h4)
    else $error("source level not four after reset");
  reset_status_a: assert property (
    $rose(presetn) |-> new_lvl_q == 4'h0 && vec_q == 7'h00 && !irq_req)
    else $error("status not zero after reset");
  zero_disables_a: assert property (
    irq_req && !$past(trap_pend) |-> irq_level != 4'h0 && irq_level < 4'h8)
    else $error("disabled source selected");
  level_fields_a: assert property (
    wr && hit_p01 |=> lvl_q[1] == $past(pwdata[14:12]) &&
    lvl_q[0] == $past(pwdata[10:8]))
    else $error("pair zero or one level not written");
  pair2to5_fields_a: assert property (
    wr && hit_p25 |=> lvl_q[5] == $past(pwdata[14:12]) &&
    lvl_q[4] == $past(pwdata[10:8]) && lvl_q[3] == $past(pwdata[6:4]) &&
    lvl_q[2] == $past(pwdata[2:0]))
    else $error("pairs two to five level not written");
  pair6_field_a: assert property (
    wr && hit_p6 |=> lvl_q[6] == $past(pwdata[2:0]))
    else $error("pair six level not written");
  unused_zero_a: assert property (
    setup && !pwrite && (hit_p01 || hit_p25 || hit_p6) |=>
    prdata[31:15] == '0 && !prdata[11] && !prdata[7] && !prdata[3] &&
    (!$past(hit_p01) || prdata[7:0] == 8'h00) &&
    (!$past(hit_p6) || prdata[14:3] == '0))
    else $error("unimplemented bits not zero");
  status_read_a: assert property (
    setup && !pwrite && hit_pvs |=> prdata[31:12] == '0 &&
    prdata[11:8] == $past(new_lvl_q) && !prdata[7] &&
    prdata[6:0] == $past(vec_q))
    else $error("status word does not carry level and vector");
  vec_track_a: assert property (
    !trap_pend && user_pend |=> irq_vector == $past(best_idx))
    else $error("vector index does not follow winner");
  trap_vector_a: assert property (
    trap_pend |=> irq_level == 4'hF && irq_vector == 7'h00)
    else $error("trap not offered at level fifteen");
  trap_unmasked_a: assert property (
    trap_flag_q && cpu_q < 4'hF && !take |=> irq_req)
    else $error("trap not requested");
  level7_masks_a: assert property (
    cpu_q == 4'h7 |-> !user_pend)
    else $error("user source passed level seven");
  cpu_write_a: assert property (
    wr && hit_lvl && !take && !handler_return |=>
    cpu_q == $past(pwdata[3:0]))
    else $error("cpu level write lost");
  tmask_blocks_a: assert property (
    tmask_on |-> !user_pend || best_lvl == 3'h7)
    else $error("timed mask let a low level through");
  tmask_load_a: assert property (
    timed_mask_start |=> tmask_q == TMASK_COUNT)
    else $error("timed mask not loaded");
  tmask_expire_a: assert property (
    tmask_q == 16'h0001 && !timed_mask_start |=> !tmask_on)
    else $error("timed mask did not expire");
  entry_level_a: assert property (
    s_enter |=> cpu_q == $past(win_lvl) && saved_q == $past(cpu_q) &&
    in_handler_q && state_q == IPC_ACTIVE && !irq_req)
    else $error("entry did not raise level");
  return_level_a: assert property (
    s_return |=> cpu_q == $past(saved_q) && state_q == IPC_IDLE)
    else $error("return did not restore level");
  re_request_a: assert property (
    s_return ##1 s_offer |=> irq_req)
    else $error("pending source not requested after return");
  flag_set_a: assert property (
    src_event != '0 |=> (flag_q & $past(src_event)) == $past(src_event))
    else $error("source event did not set its flag");
  trap_set_a: assert property (
    trap_event |=> trap_flag_q)
    else $error("trap event did not set its flag");
  trap_sticky_a: assert property (
    trap_flag_q && !(wr && hit_ctl) |=> trap_flag_q)
    else $error("trap flag dropped without clear");
  nest_write_a: assert property (
    wr && hit_ctl |=> nest_off_q == $past(pwdata[`IPC_NEST_OFF_BIT]))
    else $error("nesting off bit not written");
  nest_block_a: assert property (
    nest_off_q && in_handler_q && !trap_flag_q |-> !user_pend)
    else $error("nesting off but preemption pending");
  apb_ready_a: assert property (
    setup |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  error_ready_a: assert property (
    pslverr |-> pready)
    else $error("error without ready");
  event_clear_a: assert property (
    rd && hit_evs && !trap_event && !take |=> evs_q == 2'b00)
    else $error("event status read did not clear");
  irq_out_level_a: assert property (
    (evs_q & evm_q) != 2'b00 && !(rd && hit_evs) |=> irq_out)
    else $error("unmasked event without interrupt");
endmodule // ipc_ctrl

// File: src/ipc_map.svh
// register offsets, field positions, reset values and timing counts
// assumes: included by the interrupt priority controller sources
`ifndef IPC_MAP_SVH
`define IPC_MAP_SVH
`define IPC_OFS_PAIR01      12'h000
`define IPC_OFS_PAIR2TO5    12'h004
`define IPC_OFS_PAIR6       12'h008
`define IPC_OFS_PEND_STATUS 12'h00C
`define IPC_OFS_CONTROL     12'h010
`define IPC_OFS_FLAGS       12'h014
`define IPC_OFS_ENABLES     12'h018
`define IPC_OFS_CPU_LEVEL   12'h01C
`define IPC_OFS_EVT_STATUS  12'h020
`define IPC_OFS_EVT_MASK    12'h024
`define IPC_LEVEL_RESET     3'h4
`define IPC_NEST_OFF_BIT    15
`define IPC_TMASK_CYCLES    16'h0010
`define IPC_VEC_BASE        8'h08
`endif

// File: src/ipc_pkg.sv
// types shared by the interrupt priority controller
// assumes: nothing beyond the map header
package ipc_pkg;
  typedef logic [2:0] ipc_level_t;
  typedef logic [3:0] ipc_cpu_level_t;
  typedef enum logic [1:0] {
    IPC_IDLE   = 2'b00,
    IPC_ACTIVE = 2'b01
  } ipc_state_t;
endpackage

// File: bench/ipc_cpu_model.sv
// cpu core model: takes vectored requests, runs a handler, returns
// assumes: pclk and active-low presetn shared with the controller
`timescale 1ns/1ps
module ipc_cpu_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       irq_req,
  input  wire logic       accept,
  input  wire logic [3:0] delay,
  output logic            irq_ack,
  output logic            handler_return
);
  int   cnt_q;
  logic busy_q;
  // =========================================
  // accept after delay, return seven cycles later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q          <= 0;
      busy_q         <= 1'b0;
      irq_ack        <= 1'b0;
      handler_return <= 1'b0;
    end else begin
      irq_ack        <= 1'b0;
      handler_return <= 1'b0;
      if (!busy_q && irq_req && accept && !irq_ack) begin
        // slow cpu: delay cycles of latency before taking the request
        if (cnt_q >= delay) begin
          irq_ack <= 1'b1;
          busy_q  <= 1'b1;
          cnt_q   <= 0;
        end else begin
          cnt_q <= cnt_q + 1;
        end
      end else if (busy_q) begin
        if (cnt_q == 6) begin
          handler_return <= 1'b1;
          busy_q         <= 1'b0;
          cnt_q          <= 0;
        end else begin
          cnt_q <= cnt_q + 1;
        end
      end
    end
  end
endmodule // ipc_cpu_model

// File: bench/interrupt_priority_controller_bench.sv
// self-checking bench for the interrupt priority controller
// assumes: ipc_pkg, ipc_ctrl and ipc_cpu_model compiled before it
`timescale 1ns/1ps
module interrupt_priority_controller_bench;
  import ipc_pkg::*;
  logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]    paddr = 0;
  logic [31:0]    pwdata = 0, prdata, rd;
  logic           pready, pslverr, err, trap_event = 0, timed_mask_start = 0;
  logic [6:0]     src_event = 0, irq_vector, m;
  logic           irq_req, irq_out, irq_ack, handler_return, accept = 0;
  logic [3:0]     delay = 0;
  ipc_cpu_level_t irq_level, cpu_level;
  int             failures = 0, tests_run = 0, seed = 32'hf3d81fcf, mx, vx;
  int             lvl [7];
  always #4 pclk = ~pclk;
  ipc_ctrl #(.TMASK_COUNT(16'h0010)) u_ipc_ctrl (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .src_event, .trap_event, .irq_ack, .handler_return, .timed_mask_start,
    .irq_req, .irq_vector, .irq_level, .cpu_level, .irq_out);
  ipc_cpu_model u_ipc_cpu_model (.pclk, .presetn, .irq_req, .accept,
    .delay, .irq_ack, .handler_return);
  // =========================================
  // shared tasks
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      failures++;
      summarize;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // bounded wait: 0 request, 1 cpu level, 2 offered level
  task automatic wt(int s, logic [3:0] v);
    int k;
    for (k = 0; k < 60; k++) begin
      if ((s == 0 ? {3'h0, irq_req} : s == 1 ? cpu_level : irq_level) === v)
        break;
      @(posedge pclk);
    end
    chk("awaited signal", 1, k < 60);
    if (k >= 60)
      summarize;
  endtask
  task automatic fire(logic [6:0] f, logic t);
    src_event <= f;
    trap_event <= t;
    @(posedge pclk);
    src_event <= 7'h00;
    trap_event <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  function automatic logic [31:0] w28;
    return 32'(lvl[5] << 12 | lvl[4] << 8 | lvl[3] << 4 | lvl[2]);
  endfunction
  task automatic setlv;
    apb(1'b1, 12'h000, 32'(lvl[1] << 12 | lvl[0] << 8));
    apb(1'b1, 12'h004, w28());
    apb(1'b1, 12'h008, 32'(lvl[6]));
  endtask
  // =========================================
  // main sequence
  logic [31:0] rv [4] = '{32'h4400, 32'h4444, 32'h0004, 32'h0000};
  logic [31:0] wm [4] = '{32'h7700, 32'h7777, 32'h0007, 32'h0000};
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 0);
      chk("reset word", rv[i], rd);
      apb(1'b1, 12'(4 * i), 32'hFFFFFFFF);
      apb(1'b0, 12'(4 * i), 0);
      chk("ones readback", wm[i], rd);
    end
    apb(1'b0, 12'h0FC, 0);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    apb(1'b1, 12'h010, 32'h8000);
    apb(1'b0, 12'h010, 0);
    chk("nesting off", 32'h8000, rd & 32'h8000);
    apb(1'b1, 12'h010, 0);
    apb(1'b1, 12'h014, 0);
    apb(1'b1, 12'h018, 32'h7F);
    for (int t = 0; t < 12; t++) begin
      mx = 0;
      m = 7'($random(seed));
      for (int i = 0; i < 7; i++) begin
        lvl[i] = $random(seed) & 7;
        if (m[i] && lvl[i] > mx)
          mx = lvl[i];
      end
      vx = 0;
      for (int i = 6; i >= 0; i--)
        if (m[i] && lvl[i] == mx && mx > 0)
          vx = i + 1;
      setlv;
      apb(1'b0, 12'h004, 0);
      chk("pair2to5", w28(), rd);
      fire(m, 1'b0);
      chk("request", mx > 0, irq_req);
      if (mx > 0) begin
        chk("offered level", mx, irq_level);
        chk("offered vector", vx, irq_vector);
        apb(1'b0, 12'h00C, 0);
        chk("status level", mx, rd[11:8]);
        chk("status vector", vx, rd[6:0]);
      end
      apb(1'b1, 12'h014, 0);
      wt(0, 0);
    end
    lvl = '{3, 3, 3, 3, 3, 3, 3};
    setlv;
    fire(7'h0C, 1'b0);
    chk("tie vector", 3, irq_vector);
    apb(1'b1, 12'h014, 0);
    lvl = '{5, 0, 0, 0, 0, 0, 0};
    setlv;
    fire(7'h01, 1'b0);
    delay <= 4'h2;
    accept <= 1'b1;
    wt(1, 5);
    wt(1, 0);
    accept <= 1'b0;
    wt(0, 1);
    apb(1'b1, 12'h014, 0);
    apb(1'b1, 12'h01C, 32'h7);
    lvl[0] = 7;
    setlv;
    fire(7'h01, 1'b0);
    chk("masked at seven", 0, irq_req);
    fire(7'h00, 1'b1);
    chk("trap level", 15, irq_level);
    chk("trap vector", 0, irq_vector);
    repeat (6) @(posedge pclk);
    chk("trap held", 1, irq_req);
    apb(1'b1, 12'h010, 0);
    apb(1'b1, 12'h01C, 0);
    wt(2, 7);
    apb(1'b1, 12'h014, 0);
    lvl[0] = 6;
    lvl[1] = 7;
    setlv;
    timed_mask_start <= 1'b1;
    @(posedge pclk);
    timed_mask_start <= 1'b0;
    fire(7'h01, 1'b0);
    chk("timed mask", 0, irq_req);
    fire(7'h02, 1'b0);
    chk("seven passes", 7, irq_level);
    apb(1'b1, 12'h014, 32'h1);
    wt(2, 6);
    apb(1'b1, 12'h014, 0);
    apb(1'b0, 12'h020, 0);
    apb(1'b1, 12'h024, 0);
    fire(7'h00, 1'b1);
    chk("event masked", 0, irq_out);
    apb(1'b1, 12'h024, 32'h2);
    repeat (2) @(posedge pclk);
    chk("event out", 1, irq_out);
    apb(1'b0, 12'h020, 0);
    chk("trap event", 1, rd[1]);
    repeat (2) @(posedge pclk);
    chk("read clears", 0, irq_out);
    apb(1'b1, 12'h010, 0);
    summarize;
  end
endmodule // interrupt_priority_controller_bench
